// file: srbm_pkg.sv
// constants for the shadow rom / banked dram memory control block
// assumes an 8-bit processor bus with 16-bit addresses, one core clock
// Function
// - boot rom overlay on after reset
// - software switches overlay off and on
// - rom decodes fixed at 0000h-0fffh
// - disabled rom answers no address
// - dram array switchable on and off
// - shared region visible in every bank
// - refresh only in fetch or wait
// - 2k or 4k rom by strap
// - 2k rom mirrored in both halves
package srbm_pkg;
	localparam logic [15:0] ROM_BASE = 16'h0000;
	localparam logic [15:0] ROM_LAST = 16'h0fff;
	localparam logic [7:0] ROM_CTRL_PORT = 8'h1f;
	localparam logic [7:0] MEM_CTRL_PORT = 8'h1d;
	localparam int ROM_EN_BIT = 0;
	localparam int RAM_EN_BIT = 0;
	localparam int BANK_BIT = 1;
	localparam logic ROM_EN_RST = 1'b1;
	localparam logic RAM_EN_RST = 1'b1;
	localparam logic BANK_RST = 1'b0;
	localparam logic [3:0] SHARED_TOP_RST = 4'hf;
	localparam int SHARED_LSB = 4;
	localparam int REFRESH_ROWS = 128;
	localparam int REFRESH_PERIOD_NS = 15600;
	localparam int CLK_PERIOD_NS = 4;
	localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
endpackage : srbm_pkg

// file: srbm_mem_ctrl.sv
// memory control: rom overlay decode, dram bank select and hidden refresh
// assumes bus inputs are synchronous to core_clk; board straps are pins
`timescale 1ns/1ps
module srbm_mem_ctrl #(
	parameter int ROW_W = 7,
	parameter int REFRESH_CYCLES = srbm_pkg::REFRESH_CYCLES
) (
	input wire logic core_clk, // processor clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [15:0] cpu_addr, // memory or i/o address
	input wire logic [7:0] cpu_wdata, // write data
	input wire logic mem_req, // memory cycle active
	input wire logic io_wr, // i/o write strobe, one cycle
	input wire logic opcode_fetch_cycle, // opcode fetch in progress
	input wire logic wait_state, // processor held in wait
	input wire logic rom_4k_strap, // board option: 1 = 4k rom
	input wire logic ram_128k_strap, // board option: 1 = 128k ram
	output logic rom_sel, // rom chip select
	output logic [11:0] rom_addr, // rom address
	output logic ram_sel, // dram access select
	output logic ram_bank, // upper 64k bank address bit
	output logic refresh_req, // refresh strobe to dram
	output logic [ROW_W-1:0] refresh_row, // row being refreshed
	output logic rom_enabled, // overlay state
	output logic refresh_due // refresh owed
);
	initial begin
		if (ROW_W < 1 || ROW_W > 16 || REFRESH_CYCLES < 2)
			$error("srbm_mem_ctrl: unsupported parameters");
		// the interval counter is 16 bits wide
		if (REFRESH_CYCLES > 65536)
			$error("srbm_mem_ctrl: refresh interval too long");
	end

	// straps: two flip-flops before use
	logic [1:0] s1_q, s2_q, s1_d, s2_d;
	logic rom_en_q, rom_en_d, ram_en_q, ram_en_d, bank_q, bank_d;
	logic [3:0] shared_q, shared_d;
	logic [ROW_W-1:0] row_q, row_d;
	logic [15:0] cnt_q, cnt_d;
	logic due_q, due_d, ref_q, ref_d;
	logic in_rom, shared_hit, hidden_slot;

	always_comb begin
		s1_d = {rom_4k_strap, ram_128k_strap};
		s2_d = s1_q;
		rom_en_d = rom_en_q;
		ram_en_d = ram_en_q;
		bank_d = bank_q;
		shared_d = shared_q;
		if (io_wr && cpu_addr[7:0] == srbm_pkg::ROM_CTRL_PORT)
			rom_en_d = cpu_wdata[srbm_pkg::ROM_EN_BIT];
		// memory control port: bit 0 ram on, bit 1 bank, top nibble is the
		// first 4k page that every bank shares; writing 0 there shares all
		// of memory, so software trades bank room for common room
		if (io_wr && cpu_addr[7:0] == srbm_pkg::MEM_CTRL_PORT) begin
			ram_en_d = cpu_wdata[srbm_pkg::RAM_EN_BIT];
			bank_d = cpu_wdata[srbm_pkg::BANK_BIT];
			shared_d = cpu_wdata[7:4];
		end
	end

	// rom comes up enabled with no software help
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			rom_en_q <= srbm_pkg::ROM_EN_RST;
			ram_en_q <= srbm_pkg::RAM_EN_RST;
			bank_q <= srbm_pkg::BANK_RST;
			shared_q <= srbm_pkg::SHARED_TOP_RST;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			rom_en_q <= rom_en_d;
			ram_en_q <= ram_en_d;
			bank_q <= bank_d;
			shared_q <= shared_d;
		end
	end

	// overlay decode; the window stays 4k even with a 2k part
	always_comb begin
		in_rom = rom_en_q && cpu_addr <= srbm_pkg::ROM_LAST;
		rom_sel = mem_req && in_rom;
		rom_addr = {s2_q[1] ? cpu_addr[11] : 1'b0, cpu_addr[10:0]};
		// addresses at or above the shared boundary ignore the bank bit
		shared_hit = cpu_addr[15:12] >= shared_q;
		ram_sel = mem_req && ram_en_q && !in_rom;
		ram_bank = s2_q[0] && bank_q && !shared_hit;
	end

	// refresh rides only on fetch and wait cycles, an owed one waits for the next slot;
	// a long run with no such slot delays refresh, it never stalls the bus
	// limitation: only one refresh is owed at a time, a second is lost
	always_comb begin
		hidden_slot = opcode_fetch_cycle || wait_state;
		cnt_d = cnt_q + 16'h0001;
		due_d = due_q;
		if (cnt_q == 16'(REFRESH_CYCLES - 1)) begin
			cnt_d = 16'h0000;
			due_d = 1'b1;
		end
		ref_d = due_q && hidden_slot && ram_en_q;
		row_d = row_q;
		if (ref_d) begin
			due_d = cnt_q == 16'(REFRESH_CYCLES - 1);
			row_d = row_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			due_q <= 1'b0;
			ref_q <= 1'b0;
			row_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			due_q <= due_d;
			ref_q <= ref_d;
			row_q <= row_d;
		end
	end

	assign refresh_req = ref_q;
	assign refresh_row = row_q;
	assign rom_enabled = rom_en_q;
	assign refresh_due = due_q;

	a_rom_reset_on: assert property (@(posedge core_clk)
		$past(rst) |-> rom_en_q) else $error("rom not on after reset");
	a_rom_port_write: assert property (@(posedge core_clk) disable iff (rst)
		io_wr && cpu_addr[7:0] == srbm_pkg::ROM_CTRL_PORT
		|=> rom_en_q == $past(cpu_wdata[srbm_pkg::ROM_EN_BIT]))
		else $error("rom enable write lost");
	a_rom_range: assert property (@(posedge core_clk) disable iff (rst)
		rom_sel |-> cpu_addr[15:12] == 4'h0 && rom_en_q)
		else $error("rom outside range");
	a_rom_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
		!rom_en_q |-> !rom_sel) else $error("disabled rom selected");
	a_ram_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
		!ram_en_q |-> !ram_sel && !refresh_req) else $error("ram off active");
	a_shared_fixed: assert property (@(posedge core_clk) disable iff (rst)
		cpu_addr[15:12] >= shared_q |-> !ram_bank) else $error("shared banked");
	a_refresh_hidden: assert property (@(posedge core_clk) disable iff (rst)
		refresh_req |-> $past(opcode_fetch_cycle || wait_state))
		else $error("refresh outside slot");
	a_rom_mirror: assert property (@(posedge core_clk) disable iff (rst)
		!s2_q[1] |-> !rom_addr[11]) else $error("2k rom not mirrored");
	a_rom_excl: assert property (@(posedge core_clk) disable iff (rst)
		!(rom_sel && ram_sel)) else $error("rom and ram both selected");

	// register state after reset and under port writes
	a_ram_reset_on: assert property (@(posedge core_clk)
		$past(rst) |-> ram_en_q && !bank_q && shared_q == 4'hf)
		else $error("ram control not at reset values");
	a_strap_reset: assert property (@(posedge core_clk)
		$past(rst) |-> s2_q == 2'h0) else $error("strap sync not cleared");
	a_ram_port_write: assert property (@(posedge core_clk) disable iff (rst)
		io_wr && cpu_addr[7:0] == srbm_pkg::MEM_CTRL_PORT
		|=> ram_en_q == $past(cpu_wdata[srbm_pkg::RAM_EN_BIT]))
		else $error("ram enable write lost");
	a_bank_port_write: assert property (@(posedge core_clk) disable iff (rst)
		io_wr && cpu_addr[7:0] == srbm_pkg::MEM_CTRL_PORT
		|=> bank_q == $past(cpu_wdata[1]) && shared_q == $past(cpu_wdata[7:4]))
		else $error("bank write lost");
	a_rom_en_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(io_wr && cpu_addr[7:0] == srbm_pkg::ROM_CTRL_PORT)
		|=> $stable(rom_en_q)) else $error("rom enable moved");
	a_ram_en_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(io_wr && cpu_addr[7:0] == srbm_pkg::MEM_CTRL_PORT)
		|=> $stable(ram_en_q)) else $error("ram enable moved");
	a_bank_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(io_wr && cpu_addr[7:0] == srbm_pkg::MEM_CTRL_PORT)
		|=> $stable(bank_q) && $stable(shared_q))
		else $error("bank setting moved");

	// decode
	a_rom_hit: assert property (@(posedge core_clk) disable iff (rst)
		mem_req && rom_en_q && cpu_addr[15:12] == 4'h0 |-> rom_sel && !ram_sel)
		else $error("rom range not decoded");
	a_rom_low_addr: assert property (@(posedge core_clk) disable iff (rst)
		rom_sel |-> rom_addr[10:0] == cpu_addr[10:0])
		else $error("rom address wrong");
	a_rom_4k_addr: assert property (@(posedge core_clk) disable iff (rst)
		s2_q[1] |-> rom_addr == cpu_addr[11:0])
		else $error("4k rom address wrong");
	a_ram_banked: assert property (@(posedge core_clk) disable iff (rst)
		cpu_addr[15:12] < shared_q |-> ram_bank == (s2_q[0] && bank_q))
		else $error("bank bit wrong");

	// refresh bookkeeping
	a_refresh_due: assert property (@(posedge core_clk) disable iff (rst)
		refresh_req |-> $past(due_q)) else $error("refresh not owed");
	a_due_waits: assert property (@(posedge core_clk) disable iff (rst)
		due_q && !(opcode_fetch_cycle || wait_state) |=> due_q)
		else $error("owed refresh dropped");
	a_due_set: assert property (@(posedge core_clk) disable iff (rst)
		cnt_q == 16'(REFRESH_CYCLES - 1) |=> due_q)
		else $error("refresh not owed at interval");
	a_refresh_row: assert property (@(posedge core_clk) disable iff (rst)
		refresh_req |-> refresh_row == ROW_W'($past(refresh_row) + 1'b1))
		else $error("refresh row not stepped");

	c_rom_read: cover property (@(posedge core_clk) rom_sel);
	c_rom_off: cover property (@(posedge core_clk) $fell(rom_en_q));
	c_refresh: cover property (@(posedge core_clk) refresh_req);
	c_bank_hi: cover property (@(posedge core_clk) ram_sel && ram_bank);
	c_shared: cover property (@(posedge core_clk)
		ram_sel && bank_q && cpu_addr[15:12] >= shared_q);
endmodule : srbm_mem_ctrl

// file: srbm_cpu_model.sv
// processor bus partner: opcode fetch and wait levels from a free lfsr
// assumes core_clk and rst of the memory control block
`timescale 1ns/1ps
module srbm_cpu_model (
	input wire logic core_clk, // processor clock
	input wire logic rst, // synchronous reset
	output logic opcode_fetch_cycle, // fetch level
	output logic wait_state // wait level
);
	logic [7:0] s_q = 8'h5a;
	// sparse slots so refresh has to wait for them
	always_ff @(posedge core_clk) begin
		s_q <= {s_q[6:0], s_q[7] ^ s_q[5] ^ s_q[4] ^ s_q[3]};
		opcode_fetch_cycle <= !rst && s_q[2:0] == 3'h0;
		wait_state <= !rst && s_q[4:2] == 3'h7;
	end
endmodule : srbm_cpu_model

// file: tb_top.sv
// bench for srbm_mem_ctrl: random decode against a queue-free model
// assumes a 4 ns core_clk and REFRESH_CYCLES shortened to 8
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 0, rst = 1, mem_req = 0, io_wr = 0, f, w;
	logic s4 = 0, s128 = 0, rom_sel, ram_sel, ram_bank, rq, re, due;
	logic [15:0] a = 16'h0000, r = 16'd32613;
	logic [7:0] d = 8'h00;
	logic [11:0] ra;
	logic [6:0] row;
	int errors = 0, n_compared = 0, rom_on = 1, ram_on = 1, bk = 0;
	int shr = 15, nref = 0, slot = 0;
	int tp[6] = '{'h1f, 'h1f, 'h1d, 'h1d, 'h1d, 'h1e};
	int td[6] = '{'h00, 'h01, 'h83, 'h00, 'h03, 'h00};
	initial forever #2 core_clk = ~core_clk;
	srbm_cpu_model srbm_cpu_model_inst (.core_clk(core_clk), .rst(rst),
		.opcode_fetch_cycle(f), .wait_state(w));
	srbm_mem_ctrl #(.REFRESH_CYCLES(8)) srbm_mem_ctrl_inst (
		.core_clk(core_clk), .rst(rst), .cpu_addr(a), .cpu_wdata(d),
		.mem_req(mem_req), .io_wr(io_wr), .opcode_fetch_cycle(f),
		.wait_state(w), .rom_4k_strap(s4), .ram_128k_strap(s128),
		.rom_sel(rom_sel), .rom_addr(ra), .ram_sel(ram_sel),
		.ram_bank(ram_bank), .refresh_req(rq), .refresh_row(row),
		.rom_enabled(re), .refresh_due(due));
	function automatic logic [15:0] lf(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lf
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (e !== g) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic sweep;
		logic rs;
		for (int i = 0; i < 40; i++) begin
			r = lf(r);
			@(posedge core_clk) a <= r >> (i % 4 * 2);
			mem_req <= 1;
			@(negedge core_clk) rs = rom_on && a < 16'h1000;
			chk("rom_en", rom_on, re);
			chk("rom_sel", rs, rom_sel);
			chk("ram_sel", ram_on && !rs, ram_sel);
			chk("bank", s128 && bk && a[15:12] < shr, ram_bank);
			chk("rom_addr", s4 ? a[11:0] : {1'b0, a[10:0]}, ra);
		end
	endtask : sweep
	// refresh may only follow a fetch or wait cycle with ram on
	// sampled mid-cycle so bench state written at the edge is settled
	always @(negedge core_clk) begin
		if (rq === 1'b1) begin
			nref++;
			chk("refresh slot", 1, slot);
			chk("refresh row", nref % 128, row);
		end
		slot = !rst && (f | w) && ram_on;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		repeat (3) @(posedge core_clk);
		chk("reset rom", 1, re);
		chk("reset due", 0, due);
		chk("reset row", 0, row);
		sweep();
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk) io_wr <= 1;
			a <= tp[k];
			d <= td[k];
			s4 <= k < 3;
			s128 <= k > 0;
			@(posedge core_clk) io_wr <= 0;
			if (tp[k] == 'h1f) rom_on = td[k] & 1;
			else if (tp[k] == 'h1d) begin
				shr = td[k] >> 4;
				bk = td[k] >> 1 & 1;
				ram_on = td[k] & 1;
			end
			repeat (3) @(posedge core_clk);
			sweep();
			$display("test %0d done", k);
		end
		chk("refresh seen", 1, nref > 0);
		report_and_stop();
	end
endmodule : tb_top
